// ==== pin_sync.sv ====
// Two-flop synchroniser for levels arriving from outside the core clock domain
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic i_clk, // Core clock
   input wire logic i_rst_b, // Synchronous reset, active low
   input wire logic [W-1:0] i_async, // Raw pin levels
   output logic [W-1:0] o_sync // Levels after two flops
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // Next values of both stages
   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   // Register both stages
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule
`default_nettype wire

// ==== boot_clock_reset_config.sv ====
// Constants and top module of the start-up boot, clock and reset configuration block
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

package boot_cfg_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_VECTOR = 8'h08;
   // Reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [23:0] RESET_VECTOR_DEFAULT = 24'h00_0000;
   // Memory clock release modes
   localparam logic [1:0] MEMCLK_DRIVE_BOTH = 2'h0;
   localparam logic [1:0] MEMCLK_HIZ_SECOND = 2'h1;
   // Timing: reference clock loss watchdog
   localparam int CLK_PERIOD_NS = 40;
   localparam int REF_LOSS_NS = 2000;
   localparam int REF_LOSS_CYCLES = REF_LOSS_NS / CLK_PERIOD_NS;
   // Bus owner identity that means a single processor
   localparam logic [1:0] IDENT_SINGLE = 2'h0;

   typedef enum logic [1:0] {BOOT_MEMORY, BOOT_HOST, BOOT_NONE} boot_mode_t;

   // Software control register
   typedef struct packed {
      logic [26:0] pad;
      logic boot_done;       // Write 1: boot load finished
      logic [1:0] clk_hiz;   // Memory clock release mode
      logic clkgen_internal; // Crystal oscillator in use
      logic host_width;      // Host bus width select
   } control_t;

   // Read-only status register
   typedef struct packed {
      logic [23:0] pad;
      logic test_reset;
      logic ref_alive;
      logic [1:0] ident;
      logic bus_owner;
      logic boot_active;
      logic [1:0] mode;
   } status_t;

   // Pins crossing into the core clock domain
   typedef struct packed {
      logic ref_clk;
      logic bms_in;
      logic boot_src;
      logic proc_rst_n;
      logic test_rst_n;
      logic bus_grant;
      logic [1:0] ident;
   } pins_t;
endpackage

module boot_clock_reset_config #(
   parameter logic [23:0] RESET_VECTOR = boot_cfg_pkg::RESET_VECTOR_DEFAULT
) (
   input wire logic i_clk, // Core 2x clock, 25 MHz
   input wire logic i_rst_b, // Synchronous reset, active low
   input wire logic i_hsel, // AHB slave select
   input wire logic [31:0] i_haddr, // AHB address
   input wire logic [1:0] i_htrans, // AHB transfer type
   input wire logic i_hwrite, // AHB write
   input wire logic [2:0] i_hsize, // AHB size, word only
   input wire logic [31:0] i_hwdata, // AHB write data
   input wire logic i_hready, // AHB bus ready
   output logic [31:0] o_hrdata, // AHB read data
   output logic o_hreadyout, // AHB slave ready
   output logic o_hresp, // AHB response, always OKAY
   input wire logic i_reference_clock_in, // 1x reference clock pin
   input wire logic i_boot_source_strap, // Boot source strap
   input wire logic i_boot_memory_select_n, // Select pin, input side
   output logic o_boot_memory_select_n, // Select pin, output side
   output logic o_boot_memory_select_oe, // Select pin drive enable
   input wire logic i_proc_reset_n, // Processor reset pin, active low
   input wire logic i_test_reset_n, // Test port reset pin, active low
   input wire logic i_bus_grant, // Shared bus granted to us
   input wire logic [1:0] i_processor_identity_pins, // Processor identity
   output logic o_bus_owner_indicator, // High while owning the bus
   output logic [1:0] o_sync_mem_clock_out, // 2x memory clock pins
   output logic [1:0] o_sync_mem_clock_oe, // Memory clock drive enables
   output logic o_crystal_terminal, // Oscillator drive
   output logic o_crystal_terminal_oe, // Oscillator drive enable
   output logic o_core_tick, // Core enable at 2x reference
   output logic [1:0] o_boot_mode, // Latched boot mode
   output logic o_host_width_bit, // Host bus width select
   output logic o_fetch_start, // Pulse: start fetching
   output logic [23:0] o_fetch_addr, // Fetch address
   output logic o_test_logic_reset // Test logic held in reset
);
   boot_cfg_pkg::pins_t pins_raw;
   boot_cfg_pkg::pins_t pins;
   boot_cfg_pkg::control_t ctrl;
   boot_cfg_pkg::control_t next_ctrl;
   boot_cfg_pkg::control_t wr_ctrl;
   boot_cfg_pkg::status_t status;
   boot_cfg_pkg::boot_mode_t mode;
   boot_cfg_pkg::boot_mode_t next_mode;
   boot_cfg_pkg::boot_mode_t strap_mode;
   logic proc_rst;
   logic proc_rst_q;
   logic boot_active;
   logic next_boot_active;
   logic owner;
   logic ctrl_write;
   logic boot_done;
   logic ref_q;
   logic ref_edge;
   logic [7:0] ref_count;
   logic [7:0] next_ref_count;
   logic ref_alive;
   logic dp_write;
   logic next_dp_write;
   logic [7:0] dp_addr;
   logic [7:0] next_dp_addr;
   logic taken;
   logic [31:0] next_hrdata;
   logic next_fetch_start;
   logic [1:0] next_mem_oe;
   logic next_bms_oe;
   logic next_bms_n;
   logic next_owner;

   // Pin levels into the core clock domain
   assign pins_raw = '{ref_clk: i_reference_clock_in, bms_in: i_boot_memory_select_n,
                       boot_src: i_boot_source_strap, proc_rst_n: i_proc_reset_n,
                       test_rst_n: i_test_reset_n, bus_grant: i_bus_grant,
                       ident: i_processor_identity_pins};

   pin_sync #(
      .W($bits(boot_cfg_pkg::pins_t))
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async(pins_raw),
      .o_sync(pins)
   );

   // Decoded strap and bus decode terms
   assign proc_rst = !pins.proc_rst_n;
   assign taken = i_hsel && i_hready && i_htrans[1];
   assign ctrl_write = dp_write && (dp_addr == boot_cfg_pkg::ADDR_CONTROL);
   assign boot_done = ctrl_write && i_hwdata[4];
   assign ref_edge = pins.ref_clk != ref_q;
   assign ref_alive = ref_count < 8'(boot_cfg_pkg::REF_LOSS_CYCLES);

   // Strap decode to a boot mode
   always_comb begin
      if (pins.boot_src) begin
         strap_mode = boot_cfg_pkg::BOOT_MEMORY;
      end else if (pins.bms_in) begin
         strap_mode = boot_cfg_pkg::BOOT_HOST;
      end else begin
         strap_mode = boot_cfg_pkg::BOOT_NONE;
      end
   end

   // Boot mode, boot load progress and fetch start
   always_comb begin
      next_mode = mode;
      next_boot_active = boot_active;
      next_fetch_start = 1'b0;
      if (proc_rst) begin
         next_mode = strap_mode;
         next_boot_active = strap_mode != boot_cfg_pkg::BOOT_NONE;
      end else begin
         if (boot_active && boot_done) begin
            next_boot_active = 1'b0;
            next_fetch_start = 1'b1;
         end
         if (proc_rst_q && mode == boot_cfg_pkg::BOOT_NONE) begin
            next_fetch_start = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         mode <= boot_cfg_pkg::BOOT_NONE;
         boot_active <= 1'b0;
         proc_rst_q <= 1'b1;
         o_fetch_start <= 1'b0;
         o_fetch_addr <= 24'h00_0000;
      end else begin
         mode <= next_mode;
         boot_active <= next_boot_active;
         proc_rst_q <= proc_rst;
         o_fetch_start <= next_fetch_start;
         o_fetch_addr <= RESET_VECTOR;
      end
   end

   // Control register: cleared by processor reset, boot_done never stored
   always_comb begin
      wr_ctrl = i_hwdata;
      wr_ctrl.pad = '0;
      wr_ctrl.boot_done = 1'b0;
      next_ctrl = ctrl;
      if (proc_rst) begin
         next_ctrl = boot_cfg_pkg::CONTROL_RESET;
      end else if (ctrl_write) begin
         next_ctrl = wr_ctrl;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ctrl <= boot_cfg_pkg::CONTROL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Reference edges give two core ticks per reference period
   always_comb begin
      next_ref_count = ref_count;
      if (ref_edge) begin
         next_ref_count = 8'h00;
      end else if (ref_alive) begin
         next_ref_count = ref_count + 8'h01;
      end
      next_mem_oe = 2'h0;
      if (ctrl.clk_hiz == boot_cfg_pkg::MEMCLK_DRIVE_BOTH) begin
         next_mem_oe = 2'h3;
      end else if (ctrl.clk_hiz == boot_cfg_pkg::MEMCLK_HIZ_SECOND) begin
         next_mem_oe = 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ref_q <= 1'b0;
         ref_count <= 8'h00;
         o_core_tick <= 1'b0;
         o_sync_mem_clock_out <= 2'h0;
         o_sync_mem_clock_oe <= 2'h0;
         o_crystal_terminal <= 1'b0;
         o_crystal_terminal_oe <= 1'b0;
      end else begin
         ref_q <= pins.ref_clk;
         ref_count <= next_ref_count;
         o_core_tick <= ref_edge;
         o_sync_mem_clock_out <= {2{ref_edge}};
         o_sync_mem_clock_oe <= next_mem_oe;
         o_crystal_terminal <= ctrl.clkgen_internal && !pins.ref_clk;
         o_crystal_terminal_oe <= ctrl.clkgen_internal;
      end
   end

   // Bus ownership and boot memory select pin
   always_comb begin
      next_owner = (pins.ident == boot_cfg_pkg::IDENT_SINGLE) || pins.bus_grant;
      // Drive enable tracks the new owner value so it never outlives ownership
      next_bms_oe = !proc_rst && mode == boot_cfg_pkg::BOOT_MEMORY && next_owner;
      next_bms_n = !(boot_active && mode == boot_cfg_pkg::BOOT_MEMORY);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         owner <= 1'b0;
         o_bus_owner_indicator <= 1'b0;
         o_boot_memory_select_oe <= 1'b0;
         o_boot_memory_select_n <= 1'b1;
         o_boot_mode <= 2'h0;
         o_host_width_bit <= 1'b0;
         o_test_logic_reset <= 1'b1;
      end else begin
         owner <= next_owner;
         o_bus_owner_indicator <= next_owner;
         o_boot_memory_select_oe <= next_bms_oe;
         o_boot_memory_select_n <= next_bms_n;
         o_boot_mode <= next_mode;
         o_host_width_bit <= ctrl.host_width;
         o_test_logic_reset <= !pins.test_rst_n;
      end
   end

   // Status word seen by software
   always_comb begin
      status = '0;
      status.mode = mode;
      status.boot_active = boot_active;
      status.bus_owner = owner;
      status.ident = pins.ident;
      status.ref_alive = ref_alive;
      status.test_reset = !pins.test_rst_n;
   end

   // AHB address phase capture and registered read data
   always_comb begin
      next_dp_write = taken && i_hwrite;
      next_dp_addr = dp_addr;
      next_hrdata = o_hrdata;
      if (taken) begin
         next_dp_addr = i_haddr[7:0];
      end
      if (taken && !i_hwrite) begin
         unique case (i_haddr[7:0])
            boot_cfg_pkg::ADDR_CONTROL: next_hrdata = ctrl_write ? wr_ctrl : ctrl;
            boot_cfg_pkg::ADDR_STATUS: next_hrdata = status;
            boot_cfg_pkg::ADDR_VECTOR: next_hrdata = {8'h00, RESET_VECTOR};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         o_hrdata <= next_hrdata;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== boot_clock_reset_config_props.sv ====
// Checker on the ports of the boot, clock and reset block
`timescale 1ns/10ps
`default_nettype none
module boot_clock_reset_config_props #(
   parameter logic [23:0] RESET_VECTOR = 24'h00_0000
) (
   input wire logic i_clk, // Clock
   input wire logic i_rst_b, // Reset
   input wire logic i_reference_clock_in, // Ref pin
   input wire logic i_boot_source_strap, // Strap
   input wire logic i_boot_memory_select_n, // Select in
   input wire logic i_proc_reset_n, // Proc reset
   input wire logic [1:0] i_processor_identity_pins, // Identity
   input wire logic o_boot_memory_select_oe, // Select drive
   input wire logic o_bus_owner_indicator, // Owner
   input wire logic [1:0] o_sync_mem_clock_out, // Mem clocks
   input wire logic [1:0] o_sync_mem_clock_oe, // Mem clock drives
   input wire logic o_core_tick, // Tick
   input wire logic [1:0] o_boot_mode, // Mode
   input wire logic o_fetch_start, // Fetch pulse
   input wire logic [23:0] o_fetch_addr // Fetch address
);
   // One domain; reset stops every check
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Reference edge seen once the sync flops hold real pin values
   sequence s_ref_edge;
      $changed(i_reference_clock_in) && $past(i_rst_b) && $past(i_rst_b, 2) && $past(i_rst_b, 3);
   endsequence
   // Both memory clock pins pulse with the tick for one cycle
   sequence s_tick_pulse;
      o_sync_mem_clock_out == 2'h3 ##1 !o_core_tick;
   endsequence
   a_select_oe_mode: assert property (o_boot_memory_select_oe |-> o_boot_mode == 2'h0)
      else $error("select driven outside memory boot");
   a_select_owner: assert property (o_boot_memory_select_oe |-> o_bus_owner_indicator)
      else $error("select driven without bus ownership");
   a_owner_single: assert property ((i_processor_identity_pins == 2'h0) [*4] |=> o_bus_owner_indicator)
      else $error("single processor not shown as owner");
   a_mode_memory: assert property ((!i_proc_reset_n && i_boot_source_strap) [*4] |=> o_boot_mode == 2'h0)
      else $error("memory boot not chosen");
   a_mode_host: assert property ((!i_proc_reset_n && !i_boot_source_strap && i_boot_memory_select_n) [*4] |=> o_boot_mode == 2'h1)
      else $error("host boot not chosen");
   a_mode_held: assert property (i_proc_reset_n [*4] |=> $stable(o_boot_mode))
      else $error("boot mode changed outside reset");
   a_ref_tick: assert property (s_ref_edge |-> ##[1:4] o_core_tick)
      else $error("no core tick after reference edge");
   a_tick_pulse: assert property (o_core_tick |-> s_tick_pulse)
      else $error("memory clock pulse wrong");
   a_clock_hiz: assert property (!o_sync_mem_clock_oe[0] |-> !o_sync_mem_clock_oe[1])
      else $error("first memory clock released alone");
   a_fetch_vector: assert property (o_fetch_start |-> o_fetch_addr == RESET_VECTOR)
      else $error("fetch start away from reset vector");
endmodule
bind boot_clock_reset_config boot_clock_reset_config_props #(.RESET_VECTOR(RESET_VECTOR))
   i_boot_clock_reset_config_props (
   .i_clk, .i_rst_b, .i_reference_clock_in, .i_boot_source_strap, .i_boot_memory_select_n,
   .i_proc_reset_n, .i_processor_identity_pins, .o_boot_memory_select_oe,
   .o_bus_owner_indicator, .o_sync_mem_clock_out, .o_sync_mem_clock_oe, .o_core_tick,
   .o_boot_mode, .o_fetch_start, .o_fetch_addr);
`default_nettype wire

// ==== board_model.sv ====
// Board model: reference clock, resets and hardwired select level
`timescale 1ns/10ps
`default_nettype none
module board_model (
   input wire logic i_hold_reset, // Hold processor reset
   input wire logic i_probe_on, // Probe software started
   input wire logic i_bms_cfg, // Hardwired select level
   input wire logic i_sel_n, // Device select value
   input wire logic i_sel_oe, // Device select drive
   output logic o_ref_clk, // 1x reference clock
   output logic o_proc_reset_n, // Processor reset
   output logic o_test_reset_n, // Test port reset
   output logic o_bms_wire // Select wire level
);
   // Free-running reference at 1/8 core rate, off the core edges
   initial begin
      o_ref_clk = 1'b0;
      #13;
      forever #160 o_ref_clk = ~o_ref_clk;
   end
   // Board holds processor reset from power-up
   assign o_proc_reset_n = ~i_hold_reset;
   // Test reset low until probe software runs
   assign o_test_reset_n = i_probe_on;
   // Device drive wins, else the hardwired level
   assign o_bms_wire = i_sel_oe ? i_sel_n : i_bms_cfg;
endmodule
`default_nettype wire

// ==== boot_clock_reset_config_bench.sv ====
// Self-checking bench for the boot, clock and reset block
`timescale 1ns/10ps
`default_nettype none
module boot_clock_reset_config_bench;
   localparam logic [23:0] VEC = 24'h00_0A50;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0, ident = 2'h0, mode, mclk, mclk_oe;
   logic strap = 1'b0, cfg = 1'b1, hold = 1'b1, grant = 1'b0, probe = 1'b0;
   logic ref_clk, proc_n, trst_n, boot_memory_select_n, hready, sel_n, sel_oe, owner, tick, hostw, fstart;
   logic crys_oe, crys, tlr, hresp;
   logic [23:0] faddr;
   int fails = 0, compares = 0, nfetch = 0, nt = 0;
   // Rows: strap, hardwired select, expected mode
   logic [3:0] rows [4] = '{4'b1100, 4'b1000, 4'b0101, 4'b0010};
   always #20 clk = ~clk;
   board_model i_board_model (.i_hold_reset(hold), .i_probe_on(probe), .i_bms_cfg(cfg),
      .i_sel_n(sel_n), .i_sel_oe(sel_oe), .o_ref_clk(ref_clk), .o_proc_reset_n(proc_n),
      .o_test_reset_n(trst_n), .o_bms_wire(boot_memory_select_n));
   boot_clock_reset_config #(.RESET_VECTOR(VEC)) i_boot_clock_reset_config (
      .i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_reference_clock_in(ref_clk),
      .i_boot_source_strap(strap), .i_boot_memory_select_n(boot_memory_select_n), .o_boot_memory_select_n(sel_n),
      .o_boot_memory_select_oe(sel_oe), .i_proc_reset_n(proc_n), .i_test_reset_n(trst_n),
      .i_bus_grant(grant), .i_processor_identity_pins(ident), .o_bus_owner_indicator(owner),
      .o_sync_mem_clock_out(mclk), .o_sync_mem_clock_oe(mclk_oe), .o_crystal_terminal(crys),
      .o_crystal_terminal_oe(crys_oe), .o_core_tick(tick), .o_boot_mode(mode),
      .o_host_width_bit(hostw), .o_fetch_start(fstart), .o_fetch_addr(faddr),
      .o_test_logic_reset(tlr));
   // Count fetch pulses and memory clock ticks
   always @(posedge clk) begin
      if (fstart === 1'b1) nfetch++;
      if (tick === 1'b1 && mclk === 2'h3) nt++;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Single AHB transfer; waits on hready, read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("response", hresp, 1'b0);
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk("test logic reset", tlr, 1'b1);
      foreach (rows[i]) begin
         hold <= 1'b1;
         strap <= rows[i][3];
         cfg <= rows[i][2];
         repeat (8) @(posedge clk);
         chk("mode", mode, rows[i][1:0]);
         hold <= 1'b0;
         strap <= ~rows[i][3];
         repeat (8) @(posedge clk);
         chk("held mode", mode, rows[i][1:0]);
         ahb(1'b0, 8'h04, 32'h0);
         chk("status mode", rd[1:0], rows[i][1:0]);
         chk("select wire", boot_memory_select_n, rows[i][1:0] == 2'h0 ? 1'b0 : rows[i][2]);
         ahb(1'b1, 8'h00, 32'h0000_0011);
         ahb(1'b0, 8'h00, 32'h0);
         chk("control", rd, 32'h0000_0001);
         chk("host width", hostw, 1'b1);
         chk("select after boot", sel_n, 1'b1);
      end
      chk("fetch count", nfetch, 4);
      chk("fetch addr", faddr, VEC);
      ahb(1'b0, 8'h08, 32'h0);
      chk("vector", rd, {8'h00, VEC});
      ahb(1'b1, 8'h04, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int h = 0; h < 4; h++) begin
         ahb(1'b1, 8'h00, {28'h0, h[1:0], 2'b10});
         repeat (3) @(posedge clk);
         chk("clock drives", mclk_oe, h == 0 ? 2'h3 : h == 1 ? 2'h1 : 2'h0);
      end
      chk("crystal drive", crys_oe, 1'b1);
      // Doubled rate with internal, then external, generator
      for (int c = 0; c < 2; c++) begin
         ahb(1'b1, 8'h00, c == 0 ? 32'h2 : 32'h0);
         nt = 0;
         repeat (80) @(posedge clk);
         chk("tick count", nt inside {[19:21]}, 1'b1);
         chk("crystal drive", crys_oe, c == 0 ? 1'b1 : 1'b0);
      end
      chk("crystal idle", crys, 1'b0);
      // Shared bus: memory boot waits for the grant
      ident <= 2'h1;
      hold <= 1'b1;
      strap <= 1'b1;
      repeat (8) @(posedge clk);
      hold <= 1'b0;
      repeat (8) @(posedge clk);
      chk("owner idle", owner, 1'b0);
      chk("select idle", sel_oe, 1'b0);
      grant <= 1'b1;
      repeat (6) @(posedge clk);
      chk("owner", owner, 1'b1);
      chk("select drive", sel_oe, 1'b1);
      probe <= 1'b1;
      repeat (6) @(posedge clk);
      chk("test logic run", tlr, 1'b0);
      // Reset in mid-run
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      ahb(1'b0, 8'h00, 32'h0);
      chk("control reset", rd, boot_cfg_pkg::CONTROL_RESET);
      chk("host width reset", hostw, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
